// [shared/mac_pkg.sv]
package mac_pkg;
	// Register byte addresses
	localparam logic [31:0] MAC_CTRL_OFS = 32'h0000_0000;
	localparam logic [31:0] MAC_CMD_OFS  = 32'h0000_0004;
	localparam logic [31:0] MAC_STAT_OFS = 32'h0000_0008;
	localparam logic [31:0] MAC_IDC_OFS  = 32'h0000_000c;
	localparam logic [31:0] MAC_IAC_OFS  = 32'h0000_0010;
	localparam logic [31:0] MAC_VDC_OFS  = 32'h0000_0014;
	// Control fields
	localparam int MAC_CTRL_CONT = 0;
	localparam int MAC_CTRL_AVG  = 1;
	// Command bits, one pulse per set bit
	localparam int MAC_CMD_ARM   = 0;
	localparam int MAC_CMD_MEAS  = 1;
	localparam int MAC_CMD_TRIG  = 2;
	localparam int MAC_CMD_FETCH = 3;
	localparam int MAC_CMD_RST   = 4;
	localparam int MAC_CMD_RCL   = 5;
	localparam int MAC_CMD_CLR   = 6;
	// Reset values and limits
	localparam logic [2:0]  MAC_AVG_RST = 3'h0;
	localparam logic [2:0]  MAC_AVG_MAX = 3'h4;
	localparam logic [15:0] MAC_ERR_NONE  = 16'h0000;
	localparam logic [15:0] MAC_ERR_TRIG  = 16'hff2d; // -211
	localparam logic [15:0] MAC_ERR_STALE = 16'hff1a; // -230
	// Timing
	localparam int unsigned MAC_CLK_KHZ = 100000;
	localparam int unsigned MAC_INT_MS  = 333;
	localparam int unsigned MAC_WIN_MS  = 100;
	localparam int unsigned MAC_INT_CYC = MAC_INT_MS * MAC_CLK_KHZ;
	localparam int unsigned MAC_WIN_CYC = MAC_WIN_MS * MAC_CLK_KHZ;
endpackage

// [hdl/mac_top.sv]
`timescale 1ns/1ps
module mac_top
	import mac_pkg::*;
#(
	parameter int unsigned INT_CYC = MAC_INT_CYC, // Interval length in cycles
	parameter int unsigned WIN_CYC = MAC_WIN_CYC, // Window length in cycles
	parameter int unsigned LOG2N   = 4            // Log2 of samples per window
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [31:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic             wb_ack_o,
	output logic      [31:0] wb_dat_o,
	input  wire logic [15:0] adc_cur_i,
	input  wire logic [15:0] adc_volt_i,
	input  wire logic        adc_strobe_i
);

	// Integer square root, one bit per step; wide but only used once per interval
	function automatic logic [15:0] isqrt(input logic [31:0] x);
		logic [15:0] q;
		logic [15:0] t;
		q = '0;
		for (int b = 15; b >= 0; b--) begin
			t = q | (16'h0001 << b);
			if (32'(t) * 32'(t) <= x) q = t;
		end
		return q;
	endfunction

	// Pin synchronisers
	logic        [15:0] ci_s1_q, ci_s2_q; // Current sample
	logic        [15:0] vi_s1_q, vi_s2_q; // Voltage sample
	logic               st_s1_q, st_s2_q, st_s3_q; // Strobe chain

	// Bus state
	logic               ack_q;   // Ack, one cycle
	logic        [31:0] dat_q;   // Read data

	// Configuration and sequencing state
	logic               cont_q;  // Continuous acquisition selected
	logic         [2:0] avg_q;   // Averaging code, count is 1 << code
	logic               armed_q; // Trigger armed
	logic               pend_q;  // Request waiting for next interval
	logic               cap_q;   // Capturing intervals for a request
	logic         [4:0] nav_q;   // Intervals already captured
	logic               bufv_q;  // Buffer holds a result
	logic               ansv_q;  // Answer registers hold a result
	logic        [15:0] err_q;   // Last error code
	logic        [31:0] tmr_q;   // Interval timer
	logic         [4:0] fill_q;  // Moving history depth
	logic         [3:0] wp_q;    // History write pointer

	// Per-interval sample accumulators
	logic signed [31:0] sum_i_q; // Sum of current samples
	logic        [47:0] sq_i_q;  // Sum of squared current samples
	logic signed [31:0] sum_v_q; // Sum of voltage samples
	logic     [LOG2N:0] cnt_q;   // Samples taken this window

	// Lanes: 0 DC current, 1 AC current, 2 DC voltage
	logic signed [16:0] nres [3]; // Fresh interval result
	logic signed [16:0] buf_q [3]; // Result buffer
	logic signed [16:0] ans_q [3]; // Answer registers

	// Bus decode
	wire bus_req  = wb_cyc_i & wb_stb_i;
	wire wr_en    = bus_req & wb_we_i & ack_q & wb_sel_i[0];
	wire hit_ctrl = wb_adr_i == MAC_CTRL_OFS;
	wire hit_cmd  = wb_adr_i == MAC_CMD_OFS;
	wire wr_ctrl  = wr_en & hit_ctrl;
	wire wr_cmd   = wr_en & hit_cmd;

	// Command pulses
	wire cmd_arm   = wr_cmd & wb_dat_i[MAC_CMD_ARM];
	wire cmd_meas  = wr_cmd & wb_dat_i[MAC_CMD_MEAS];
	wire cmd_trig  = wr_cmd & wb_dat_i[MAC_CMD_TRIG];
	wire cmd_fetch = wr_cmd & wb_dat_i[MAC_CMD_FETCH];
	wire cmd_rst   = wr_cmd & wb_dat_i[MAC_CMD_RST];
	wire cmd_rcl   = wr_cmd & wb_dat_i[MAC_CMD_RCL];
	wire cmd_clr   = wr_cmd & wb_dat_i[MAC_CMD_CLR];

	// Request classification
	wire trig_ok   = cmd_trig & ~cont_q & armed_q;
	wire trig_bad  = cmd_trig & ~cont_q & ~armed_q;
	wire req_nc    = (cmd_meas | trig_ok) & ~cont_q;
	wire ans_buf   = (cmd_fetch | (cmd_meas & cont_q)) & bufv_q;
	wire fetch_bad = (cmd_fetch | (cmd_meas & cont_q)) & ~bufv_q;

	// Interval timing
	wire       ivl_end = tmr_q == INT_CYC - 1;
	wire       in_win  = tmr_q < WIN_CYC;
	wire [4:0] kval    = 5'h01 << avg_q;
	wire       done    = nav_q == kval - 5'h01;
	wire       com_nc  = ivl_end & cap_q & done & ~req_nc;
	wire       com_c   = ivl_end & cont_q;
	wire       avg_chg = wr_ctrl | cmd_rst | cmd_rcl;

	// Sample arithmetic
	wire smp_stb = st_s2_q & ~st_s3_q;
	wire take    = smp_stb & in_win & ~cnt_q[LOG2N];
	wire signed [15:0] ci = ci_s2_q;
	wire signed [15:0] vi = vi_s2_q;
	wire signed [31:0] ci2 = ci * ci;
	wire signed [31:0] idc_w = sum_i_q >>> LOG2N;
	wire signed [31:0] vdc_w = sum_v_q >>> LOG2N;
	wire        [47:0] ms_w = sq_i_q >> LOG2N;
	wire signed [31:0] dc2 = idc_w * idc_w;
	wire        [31:0] dc2u = unsigned'(dc2);
	wire        [31:0] acv = (ms_w[31:0] > dc2u) ? ms_w[31:0] - dc2u : 32'h0;
	assign nres[0] = idc_w[16:0];
	assign nres[1] = {1'b0, isqrt(acv)};
	assign nres[2] = vdc_w[16:0];

	// Averaging code as written, clamped to sixteen intervals
	wire [2:0] avg_w = (wb_dat_i[MAC_CTRL_AVG +: 3] > MAC_AVG_MAX) ? MAC_AVG_MAX
		: wb_dat_i[MAC_CTRL_AVG +: 3];

	// Read mux; unmapped addresses read zero and still ack
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0;
		case (wb_adr_i)
			MAC_CTRL_OFS: rd_mux = {28'h0, avg_q, cont_q};
			MAC_STAT_OFS: rd_mux = {err_q, 12'h0, ansv_q, bufv_q, pend_q | cap_q, armed_q};
			MAC_IDC_OFS:  rd_mux = 32'(ans_q[0]);
			MAC_IAC_OFS:  rd_mux = 32'(ans_q[1]);
			MAC_VDC_OFS:  rd_mux = 32'(ans_q[2]);
			default:      rd_mux = 32'h0;
		endcase
	end

	// Two flip-flops on every converter pin before use
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ci_s1_q <= '0;
			ci_s2_q <= '0;
			vi_s1_q <= '0;
			vi_s2_q <= '0;
			st_s1_q <= 1'b0;
			st_s2_q <= 1'b0;
			st_s3_q <= 1'b0;
		end else begin
			ci_s1_q <= adc_cur_i;
			ci_s2_q <= ci_s1_q;
			vi_s1_q <= adc_volt_i;
			vi_s2_q <= vi_s1_q;
			st_s1_q <= adc_strobe_i;
			st_s2_q <= st_s1_q;
			st_s3_q <= st_s2_q;
		end
	end

	// Bus slave: ack one cycle after request, dropped the next
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
		end else begin
			ack_q <= bus_req & ~ack_q;
			if (bus_req & ~ack_q) dat_q <= rd_mux;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Free-running interval timer and window accumulation
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || ivl_end) begin
			tmr_q   <= 32'h0;
			sum_i_q <= '0;
			sq_i_q  <= '0;
			sum_v_q <= '0;
			cnt_q   <= '0;
		end else begin
			tmr_q <= tmr_q + 32'h1;
			if (take) begin
				sum_i_q <= sum_i_q + 32'(ci);
				sq_i_q  <= sq_i_q + 48'(unsigned'(ci2));
				sum_v_q <= sum_v_q + 32'(vi);
				cnt_q   <= cnt_q + 1'b1;
			end
		end
	end

	// Configuration: changed only by control register writes, commands or reset
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cont_q  <= 1'b0;
			avg_q   <= MAC_AVG_RST;
			armed_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				cont_q <= wb_dat_i[MAC_CTRL_CONT];
				avg_q  <= avg_w;
			end
			if (cmd_rst) begin
				cont_q <= 1'b0;
				avg_q  <= MAC_AVG_RST;
			end
			if (cmd_rcl) cont_q <= 1'b0;
			if (trig_ok | cmd_rst) armed_q <= 1'b0;
			else if (cmd_arm) armed_q <= 1'b1;
		end
	end

	// Request sequencing: wait out the running interval, then capture
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || cmd_rst) begin
			pend_q <= 1'b0;
			cap_q  <= 1'b0;
			nav_q  <= 5'h0;
		end else if (req_nc) begin
			pend_q <= 1'b1;
			cap_q  <= 1'b0;
			nav_q  <= 5'h0;
		end else if (ivl_end) begin
			if (cap_q) begin
				if (done) cap_q <= 1'b0;
				else nav_q <= nav_q + 5'h01;
			end
			if (pend_q) begin
				pend_q <= 1'b0;
				cap_q  <= 1'b1;
				nav_q  <= 5'h0;
			end
		end
	end

	// Buffer and answer flags, errors; a set beats a clear in the same cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			bufv_q <= 1'b0;
			ansv_q <= 1'b0;
			err_q  <= MAC_ERR_NONE;
		end else begin
			if (req_nc | cmd_arm | cmd_rst) bufv_q <= 1'b0;
			if (com_nc | com_c) bufv_q <= 1'b1;
			if (req_nc) ansv_q <= 1'b0;
			if (com_nc | ans_buf) ansv_q <= 1'b1;
			if (cmd_clr) err_q <= MAC_ERR_NONE;
			if (fetch_bad) err_q <= MAC_ERR_STALE;
			if (trig_bad) err_q <= MAC_ERR_TRIG;
		end
	end

	// Moving history pointer and depth, restarted when averaging changes
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i || avg_chg) begin
			fill_q <= 5'h0;
			wp_q   <= 4'h0;
		end else if (com_c) begin
			wp_q <= wp_q + 4'h1;
			if (fill_q != 5'h10) fill_q <= fill_q + 5'h01;
		end
	end

	// Per-lane block averaging, moving average and buffer
	for (genvar l = 0; l < 3; l++) begin : g_lane
		logic signed [21:0] acc_q;        // Block sum, non-continuous
		logic signed [21:0] run_q;        // Moving sum, continuous
		logic signed [16:0] hist_q [16];  // Recent results, no reset needed
		wire  signed [16:0] old = (fill_q >= kval) ? hist_q[4'(wp_q - kval[3:0])] : '0;
		wire  signed [21:0] acc_n = acc_q + 22'(nres[l]);
		wire  signed [21:0] run_n = run_q + 22'(nres[l]) - 22'(old);

		// History store; old entries are gated by the fill depth
		always_ff @(posedge mclk_i) begin
			if (com_c) hist_q[wp_q] <= nres[l];
		end

		// Sums, buffer and answers
		always_ff @(posedge mclk_i) begin
			if (!rst_n_i) begin
				acc_q    <= '0;
				run_q    <= '0;
				buf_q[l] <= '0;
				ans_q[l] <= '0;
			end else begin
				if (req_nc) acc_q <= '0;
				else if (ivl_end) acc_q <= (cap_q & ~done) ? acc_n : '0;
				if (avg_chg) run_q <= '0;
				else if (com_c) run_q <= run_n;
				if (com_nc) begin
					buf_q[l] <= 17'(acc_n >>> avg_q);
					ans_q[l] <= 17'(acc_n >>> avg_q);
				end else if (com_c) begin
					buf_q[l] <= 17'(run_n >>> avg_q);
				end
				if (ans_buf) ans_q[l] <= buf_q[l];
			end
		end
	end

	// Checks
	a_bus_ack_pulse: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		bus_req && !ack_q |=> ack_q ##1 !ack_q)
		else $error("ack not a single cycle after request");
	a_trig_unarmed: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		trig_bad && !pend_q && !cmd_meas |=> err_q == MAC_ERR_TRIG && !pend_q)
		else $error("unarmed trigger not rejected");
	a_fetch_stale: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		fetch_bad && !trig_bad |=> err_q == MAC_ERR_STALE)
		else $error("empty fetch gave no stale error");
	a_buf_cleared: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(req_nc || cmd_arm || cmd_rst) && !com_c && !com_nc |=> !bufv_q)
		else $error("buffer not cleared");
	a_nc_drop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!cont_q && !cap_q |=> $stable(buf_q[0]))
		else $error("buffer written with no request");
	a_req_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		req_nc && !cmd_rst |=> pend_q && !cap_q && !bufv_q)
		else $error("request did not wait for next interval");
	a_ivl_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		ivl_end |=> tmr_q == 32'h0 && cnt_q == '0)
		else $error("interval did not restart");
	a_avg_bound: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cap_q |-> nav_q < kval && kval <= 5'h10)
		else $error("averaging ran past its count");
	a_cont_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cmd_rst || cmd_rcl |=> !cont_q)
		else $error("continuous mode survived reset");
	a_cont_trig: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		cmd_trig && cont_q |=> $stable(err_q) || $past(cmd_clr || fetch_bad))
		else $error("trigger not ignored in continuous mode");

endmodule

// [testbench/mac_adc_model.sv]
`timescale 1ns/1ps
// Converter model: steps data far from the strobe so it is stable when sampled
module mac_adc_model (
	input  wire logic        mclk_i,
	input  wire logic [15:0] cur_set_i,  // Next current sample
	input  wire logic [15:0] volt_set_i, // Next voltage sample
	output logic      [15:0] cur_o,
	output logic      [15:0] volt_o,
	output logic             strobe_o
);
	logic [2:0] ph_q; // Phase inside an 8-cycle sample slot
	// Known levels from time zero
	initial begin
		ph_q = 3'h0;
		cur_o = 16'h0000;
		volt_o = 16'h0000;
		strobe_o = 1'b0;
	end
	// Data moves at phase 0, strobe high for phases 4..6, so 3 quiet cycles before and 2 after
	always @(posedge mclk_i) begin
		ph_q <= ph_q + 3'h1;
		strobe_o <= (ph_q >= 3'h3) && (ph_q < 3'h6);
		if (ph_q == 3'h0) begin
			cur_o <= cur_set_i;
			volt_o <= volt_set_i;
		end
	end
endmodule

// [testbench/test_measurement_acquisition_control.sv]
`timescale 1ns/1ps
module test_measurement_acquisition_control
	import mac_pkg::*;
;
	localparam int unsigned IC = 200; // Short interval keeps the run brief
	localparam int unsigned WC = 60;  // Short window, still holds 4 strobes
	typedef struct packed {
		logic [31:0] e; // Expected word
		logic [31:0] m; // Mask; zero means poll only
	} mac_note_t;
	logic        mclk_i, rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, adc_strobe_i;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rq;
	logic [3:0]  wb_sel_i;
	logic [15:0] adc_cur_i, adc_volt_i, cur_s, volt_s, c, v;
	int          err_count, comparisons, now_c, t0;
	mac_note_t   notes[$];
	mac_note_t   nt;

	mac_top #(.INT_CYC(IC), .WIN_CYC(WC), .LOG2N(2)) DUT (.mclk_i(mclk_i),
		.rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
		.wb_dat_o(wb_dat_o), .adc_cur_i(adc_cur_i), .adc_volt_i(adc_volt_i),
		.adc_strobe_i(adc_strobe_i));
	mac_adc_model u_adc (.mclk_i(mclk_i), .cur_set_i(cur_s), .volt_set_i(volt_s),
		.cur_o(adc_cur_i), .volt_o(adc_volt_i), .strobe_o(adc_strobe_i));

	// 100 MHz clock
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// Free cycle count for latency checks
	always @(posedge mclk_i) now_c <= now_c + 1;

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	function automatic logic [31:0] sx(input logic [15:0] x);
		return {{16{x[15]}}, x};
	endfunction

	// Read answers are matched against the oldest note
	always @(posedge mclk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
			nt = notes.pop_front();
			if (nt.m != 32'h0) chk("rdata", nt.e, wb_dat_o & nt.m);
		end
	end

	// One classic cycle, entered just after an edge; leaves one idle cycle
	task automatic bus(input logic w, input logic [31:0] a, d, e, m);
		int n;
		if (!w) notes.push_back('{e, m});
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		// Only the watchdog ends a wait; the slave should answer on the second edge
		chk("ack_wait", 32'h2, 32'(n));
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk_i);
	endtask

	task automatic wr(input logic [31:0] a, d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask
	task automatic rd(input logic [31:0] a, e, input logic [31:0] m = 32'hffff_ffff);
		bus(1'b0, a, 32'h0, e, m);
	endtask
	task automatic cmd(input int b);
		wr(MAC_CMD_OFS, 32'h1 << b);
	endtask

	// Poll until idle with a result; span must fall in k..k+1 intervals
	task automatic wait_done(input int k);
		int i;
		t0 = now_c;
		i = 0;
		do begin
			rd(MAC_STAT_OFS, 32'h0, 32'h0);
			i++;
		end while (rq[2:1] !== 2'b10 && i < 2000);
		chk("span", 32'h1, {31'h0, (now_c - t0 >= k * IC) && (now_c - t0 <= (k + 1) * IC + 8)});
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#300000;
		err_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		int k;
		err_count = 0;
		comparisons = 0;
		now_c = 0;
		{rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = 8'h00;
		{wb_adr_i, wb_dat_i} = 64'h0;
		{cur_s, volt_s} = 32'h0;
		void'($urandom(32'h090fbcb2));
		repeat (5) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		@(posedge mclk_i);
		rd(MAC_CTRL_OFS, 32'h0);
		rd(MAC_STAT_OFS, 32'h0);
		rd(MAC_CMD_OFS, 32'h0);
		rd(32'h0000_0020, 32'h0);
		cmd(MAC_CMD_FETCH);
		rd(MAC_STAT_OFS, 32'hff1a_0000);
		cmd(MAC_CMD_CLR);
		cmd(MAC_CMD_TRIG);
		rd(MAC_STAT_OFS, 32'hff2d_0000);
		cmd(MAC_CMD_CLR);
		c = 16'($urandom);
		v = 16'($urandom);
		cur_s <= c;
		volt_s <= v;
		cmd(MAC_CMD_MEAS);
		wait_done(1);
		rd(MAC_IDC_OFS, sx(c));
		rd(MAC_IAC_OFS, 32'h0);
		rd(MAC_VDC_OFS, sx(v));
		// New samples must not reach the buffer while nothing is pending
		cur_s <= ~c;
		repeat (2 * IC + 10) @(posedge mclk_i);
		cmd(MAC_CMD_FETCH);
		rd(MAC_IDC_OFS, sx(c));
		cmd(MAC_CMD_ARM);
		rd(MAC_STAT_OFS, 32'h1, 32'h5);
		cmd(MAC_CMD_TRIG);
		wait_done(1);
		rd(MAC_IDC_OFS, sx(~c));
		rd(MAC_STAT_OFS, 32'h0, 32'hffff_0001);
		for (k = 1; k <= 4; k++) begin
			wr(MAC_CTRL_OFS, 32'(k) << 1);
			rd(MAC_CTRL_OFS, 32'(k) << 1);
			cmd(MAC_CMD_MEAS);
			wait_done(1 << k);
			rd(MAC_IDC_OFS, sx(~c));
		end
		// Continuous: buffer follows the input with no request
		wr(MAC_CTRL_OFS, 32'h1);
		c = 16'($urandom);
		cur_s <= c;
		repeat (2 * IC + 10) @(posedge mclk_i);
		cmd(MAC_CMD_MEAS);
		rd(MAC_IDC_OFS, sx(c));
		cmd(MAC_CMD_TRIG);
		rd(MAC_STAT_OFS, 32'h0, 32'hffff_0000);
		wr(MAC_CTRL_OFS, 32'h3);
		c = 16'($urandom);
		cur_s <= c;
		repeat (3 * IC + 10) @(posedge mclk_i);
		cmd(MAC_CMD_FETCH);
		rd(MAC_IDC_OFS, sx(c));
		cmd(MAC_CMD_RCL);
		rd(MAC_CTRL_OFS, 32'h2);
		wr(MAC_CTRL_OFS, 32'h1);
		cmd(MAC_CMD_RST);
		rd(MAC_CTRL_OFS, 32'h0);
		cmd(MAC_CMD_FETCH);
		rd(MAC_STAT_OFS, 32'hff1a_0000, 32'hffff_0004);
		report_and_stop();
	end
endmodule
